// >>> design/dpm_pkg.sv
// package: constants, register map and mode types for the power mode controller
package dpm_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int NUM_CORES = 2;
    localparam int SRAM_BLK_W = 4;
    // register indices (word addresses)
    localparam logic [ADDR_W-1:0] POWER_CONTROL_ADDR = 4'h0;
    localparam logic [ADDR_W-1:0] HIBERNATE_CONTROL_ADDR = 4'h1;
    localparam logic [ADDR_W-1:0] WAKE_MASK_ADDR = 4'h2;
    localparam logic [ADDR_W-1:0] DEEP_CONFIG_ADDR = 4'h3;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h4;
    // power_control_reg fields
    localparam int PC_REDUCED_BIT = 0;
    localparam int PC_READY_BIT = 1;
    // hibernate_control_reg fields
    localparam int HIB_REQ_BIT = 31;
    localparam int HIB_DISABLE_BIT = 30;
    // deep config fields
    localparam int DC_BOTH_WAKE_BIT = 0;
    localparam int DC_LS_CLK_BIT = 1;
    localparam int DC_LS_PERIPH_BIT = 2;
    localparam int DC_EXT_PERIPH_BIT = 3;
    localparam int DC_SRAM_LSB = 4;
    // status fields
    localparam int ST_SYS_LSB = 0;
    localparam int ST_CORE0_LSB = 2;
    localparam int ST_CORE1_LSB = 4;
    // regulator targets
    localparam logic [1:0] VTARGET_FULL = 2'h1;
    localparam logic [1:0] VTARGET_REDUCED = 2'h2;
    localparam logic [1:0] VTARGET_OFF = 2'h0;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

    typedef enum logic [1:0] {
        DPM_SYS_FULL,
        DPM_SYS_REDUCED,
        DPM_SYS_DEEP,
        DPM_SYS_HIB
    } dpm_sys_t;

    typedef enum logic [1:0] {
        DPM_CORE_ACTIVE,
        DPM_CORE_SLEEP,
        DPM_CORE_DEEP
    } dpm_core_t;
endpackage

// >>> design/dpm_power_mode_ctrl.sv
// system and per-core power mode controller for a dual-core device
//
// Operation
// - reset starts in full-performance mode
// - reset and wakeup make core active
// - core sleep gates that core's clock
// - each core sleeps independently
// - interrupt wakes only cores masking it in
// - mode switch changes regulator voltage target
// - no flash writes in reduced-voltage mode
// - deep sleep needs both cores requesting
// - wait for ready flag, then enter automatically
// - hibernate bit set turns deep into hibernate
// - deep sleep stops high-speed clocks
// - clockless/external-clock peripherals may keep running
// - low-speed interrupts wake from deep sleep
// - woken core active, other stays deep
// - wakeup restores prior full/reduced mode
// - optional wake of both cores together
// - debugger blocks system deep, core sleeps
// - hibernate only by register write from run
// - hibernate freezes pins, wakeup resets device
//
// Limitations
// - only the woken core leaves deep, unless wake-both
// - hibernate ends only by the reset it requests
// - reset request repeats while wake stays high
// - hibernate disable is write-once until reset
// - a debugger on either core holds a run mode
// - flash writes only in full-performance mode
// - wake masks: NUM_IRQ bits per core, at 0 and 16
// - masks wider than 16 bits would overlap
// - bus never waits; read data next cycle
// - ready flag is written, not sensed
// - status word is read-only
// - flash allow is a permission only
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module dpm_power_mode_ctrl #(
    parameter int NUM_IRQ = 8,
    parameter int SRAM_BLOCKS = 8
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // register port
    input wire logic [dpm_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [dpm_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [dpm_pkg::DATA_W-1:0] reg_rdata_out,
    // core side: wait-for-interrupt with deep-sleep select bit
    input wire logic [dpm_pkg::NUM_CORES-1:0] core_wait_in,
    input wire logic [dpm_pkg::NUM_CORES-1:0] deep_sleep_select_bit_in,
    input wire logic [dpm_pkg::NUM_CORES-1:0] debug_attached_in,
    // interrupt sources
    input wire logic [NUM_IRQ-1:0] periph_irq_in,
    input wire logic [NUM_IRQ-1:0] deep_wake_capable_in,
    input wire logic hib_wake_in,
    // clock and power controls
    output logic [dpm_pkg::NUM_CORES-1:0] core_clk_en_out,
    output logic [dpm_pkg::NUM_CORES-1:0] core_wake_out,
    output logic [1:0] regulator_target_out,
    output logic flash_write_allow_out,
    output logic high_speed_clk_en_out,
    output logic low_speed_clk_en_out,
    output logic low_speed_periph_en_out,
    output logic ext_clock_periph_en_out,
    output logic [SRAM_BLOCKS-1:0] sram_retain_out,
    output logic pin_freeze_out,
    output logic device_reset_req_out,
    output logic [1:0] sys_mode_out
);
    import dpm_pkg::*;

    // ----------------------------------------------------------------
    // state layout
    // ----------------------------------------------------------------
    // one struct: one next-state process, one register

    typedef struct packed {
        // mode machines
        dpm_sys_t sys;
        // run mode to return to after deep sleep
        logic prior_reduced;
        dpm_core_t [NUM_CORES-1:0] core;

        // software fields
        logic reduced_reg;
        logic ready_reg;
        logic hib_req_reg;
        logic hib_disable_reg;
        logic both_wake_reg;
        logic ls_clk_reg;
        logic ls_periph_reg;
        logic ext_periph_reg;
        logic [SRAM_BLK_W-1:0] sram_blocks_reg;
        logic [NUM_CORES-1:0][NUM_IRQ-1:0] wake_mask_reg;

        // registered outputs
        logic [DATA_W-1:0] rdata;
        logic [NUM_CORES-1:0] clk_en;
        logic [NUM_CORES-1:0] wake;
        logic [1:0] vtarget;
        logic flash_ok;
        logic hs_clk;
        logic ls_clk;
        logic ls_periph;
        logic ext_periph;
        logic [SRAM_BLOCKS-1:0] sram;
        logic freeze;
        logic dev_reset;
    } dpm_state_t;

    dpm_state_t state_reg;
    dpm_state_t state_next;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // lowest n blocks stay retained
    // counts above SRAM_BLOCKS retain all
    function automatic logic [SRAM_BLOCKS-1:0] dpm_thermo(input logic [SRAM_BLK_W-1:0] n);
        logic [SRAM_BLOCKS-1:0] m;
        m = '0;
        for (int i = 0; i < SRAM_BLOCKS; i++) begin
            m[i] = (i < int'(n));
        end
        return m;
    endfunction

    // full-performance or reduced-voltage
    function automatic logic dpm_run_mode(input dpm_sys_t s);
        return (s == DPM_SYS_FULL) || (s == DPM_SYS_REDUCED);
    endfunction

    // ----------------------------------------------------------------
    // wake decode
    // ----------------------------------------------------------------
    // deep wake: only sources alive without fast clocks
    // a pending masked irq also blocks deep entry

    logic [NUM_CORES-1:0] irq_hit;
    logic [NUM_CORES-1:0] deep_hit;
    logic any_debug;
    logic all_deep;

    always_comb begin
        for (int c = 0; c < NUM_CORES; c++) begin
            irq_hit[c] = |(periph_irq_in & state_reg.wake_mask_reg[c]);
            deep_hit[c] = |(periph_irq_in & deep_wake_capable_in
                            & state_reg.wake_mask_reg[c]);
        end
        any_debug = |debug_attached_in;
        all_deep = 1'b1;
        for (int c = 0; c < NUM_CORES; c++) begin
            all_deep = all_deep && (state_reg.core[c] == DPM_CORE_DEEP);
        end
    end

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.rdata = '0;
        state_next.wake = '0;
        state_next.dev_reset = 1'b0;

        // --------------------
        // register writes
        // --------------------
        // unmapped addresses change nothing
        if (reg_write_in) begin
            if (reg_addr_in == POWER_CONTROL_ADDR) begin
                state_next.reduced_reg = reg_wdata_in[PC_REDUCED_BIT];
                state_next.ready_reg = reg_wdata_in[PC_READY_BIT];
            end else if (reg_addr_in == HIBERNATE_CONTROL_ADDR) begin
                // disable bit is write-once until reset
                if (!state_reg.hib_disable_reg) begin
                    state_next.hib_disable_reg = reg_wdata_in[HIB_DISABLE_BIT];
                end
                state_next.hib_req_reg = reg_wdata_in[HIB_REQ_BIT];
            end else if (reg_addr_in == WAKE_MASK_ADDR) begin
                for (int c = 0; c < NUM_CORES; c++) begin
                    state_next.wake_mask_reg[c] = reg_wdata_in[c*16 +: NUM_IRQ];
                end
            end else if (reg_addr_in == DEEP_CONFIG_ADDR) begin
                state_next.both_wake_reg = reg_wdata_in[DC_BOTH_WAKE_BIT];
                state_next.ls_clk_reg = reg_wdata_in[DC_LS_CLK_BIT];
                state_next.ls_periph_reg = reg_wdata_in[DC_LS_PERIPH_BIT];
                state_next.ext_periph_reg = reg_wdata_in[DC_EXT_PERIPH_BIT];
                state_next.sram_blocks_reg = reg_wdata_in[DC_SRAM_LSB +: SRAM_BLK_W];
            end
        end

        // --------------------
        // register reads, data in the following cycle
        // --------------------
        // zero otherwise, so slaves can be ORed
        if (reg_read_in) begin
            if (reg_addr_in == POWER_CONTROL_ADDR) begin
                state_next.rdata[PC_REDUCED_BIT] = state_reg.reduced_reg;
                state_next.rdata[PC_READY_BIT] = state_reg.ready_reg;
            end else if (reg_addr_in == HIBERNATE_CONTROL_ADDR) begin
                state_next.rdata[HIB_REQ_BIT] = state_reg.hib_req_reg;
                state_next.rdata[HIB_DISABLE_BIT] = state_reg.hib_disable_reg;
            end else if (reg_addr_in == WAKE_MASK_ADDR) begin
                for (int c = 0; c < NUM_CORES; c++) begin
                    state_next.rdata[c*16 +: NUM_IRQ] = state_reg.wake_mask_reg[c];
                end
            end else if (reg_addr_in == DEEP_CONFIG_ADDR) begin
                state_next.rdata[DC_BOTH_WAKE_BIT] = state_reg.both_wake_reg;
                state_next.rdata[DC_LS_CLK_BIT] = state_reg.ls_clk_reg;
                state_next.rdata[DC_LS_PERIPH_BIT] = state_reg.ls_periph_reg;
                state_next.rdata[DC_EXT_PERIPH_BIT] = state_reg.ext_periph_reg;
                state_next.rdata[DC_SRAM_LSB +: SRAM_BLK_W] = state_reg.sram_blocks_reg;
            end else if (reg_addr_in == STATUS_ADDR) begin
                state_next.rdata[ST_SYS_LSB +: 2] = state_reg.sys;
                state_next.rdata[ST_CORE0_LSB +: 2] = state_reg.core[0];
                state_next.rdata[ST_CORE1_LSB +: 2] = state_reg.core[1];
            end else begin
                state_next.rdata = UNMAPPED_READ;
            end
        end

        // --------------------
        // system mode machine
        // --------------------
        case (state_reg.sys)
            DPM_SYS_FULL, DPM_SYS_REDUCED: begin
                // run mode follows the reduced-voltage select bit
                state_next.sys = state_reg.reduced_reg ? DPM_SYS_REDUCED : DPM_SYS_FULL;
                // per-core sleep handling, each core on its own
                for (int c = 0; c < NUM_CORES; c++) begin
                    case (state_reg.core[c])
                        // wait with select bit asks for deep
                        DPM_CORE_ACTIVE: begin
                            if (core_wait_in[c]) begin
                                // a debugger turns deep requests into plain sleep
                                if (deep_sleep_select_bit_in[c] && !any_debug) begin
                                    state_next.core[c] = DPM_CORE_DEEP;
                                end else begin
                                    state_next.core[c] = DPM_CORE_SLEEP;
                                end
                            end
                        end
                        default: begin
                            // sleep or run-mode deep: any masked irq
                            if (irq_hit[c]) begin
                                state_next.core[c] = DPM_CORE_ACTIVE;
                                state_next.wake[c] = 1'b1;
                            end
                        end
                    endcase
                end
                // both cores deep, system ready and no debugger
                if (all_deep && !any_debug && state_reg.ready_reg
                        && !irq_hit[0] && !irq_hit[1]) begin
                    state_next.prior_reduced = state_reg.reduced_reg;
                    // hibernate only from a run mode via the written request bit
                    if (state_reg.hib_req_reg && !state_reg.hib_disable_reg) begin
                        state_next.sys = DPM_SYS_HIB;
                    end else begin
                        state_next.sys = DPM_SYS_DEEP;
                    end
                end
            end
            DPM_SYS_DEEP: begin
                // only deep-capable sources reach the cores
                if (|deep_hit) begin
                    // return to whichever run mode was left
                    state_next.sys = state_reg.prior_reduced ? DPM_SYS_REDUCED
                                                             : DPM_SYS_FULL;
                    for (int c = 0; c < NUM_CORES; c++) begin
                        if (deep_hit[c] || state_reg.both_wake_reg) begin
                            state_next.core[c] = DPM_CORE_ACTIVE;
                            state_next.wake[c] = 1'b1;
                        end
                    end
                end
            end
            DPM_SYS_HIB: begin
                // wake pins, reset pin, comparator, watchdog, alarm: full reset
                // no exit here: the reset clears the state
                if (hib_wake_in) begin
                    state_next.dev_reset = 1'b1;
                end
            end
            default: begin
                state_next.sys = DPM_SYS_FULL;
            end
        endcase

        // --------------------
        // derived outputs from the coming state
        // --------------------
        // from state_next, so they switch with the mode
        for (int c = 0; c < NUM_CORES; c++) begin
            state_next.clk_en[c] = (state_next.core[c] == DPM_CORE_ACTIVE);
        end
        // regulator off in deep sleep and hibernate
        state_next.vtarget = VTARGET_OFF;
        if (state_next.sys == DPM_SYS_FULL) begin
            state_next.vtarget = VTARGET_FULL;
        end else if (state_next.sys == DPM_SYS_REDUCED) begin
            state_next.vtarget = VTARGET_REDUCED;
        end
        state_next.flash_ok = (state_next.sys == DPM_SYS_FULL);
        state_next.hs_clk = dpm_run_mode(state_next.sys);
        // low-speed domain runs in deep only if enabled
        state_next.ls_clk = dpm_run_mode(state_next.sys)
            || ((state_next.sys == DPM_SYS_DEEP) && state_reg.ls_clk_reg);
        state_next.ls_periph = dpm_run_mode(state_next.sys)
            || ((state_next.sys == DPM_SYS_DEEP) && state_reg.ls_periph_reg);
        state_next.ext_periph = dpm_run_mode(state_next.sys)
            || ((state_next.sys == DPM_SYS_DEEP) && state_reg.ext_periph_reg);
        // in hibernate nothing is retained or clocked
        if (state_next.sys == DPM_SYS_HIB) begin
            state_next.sram = '0;
        end else if (state_next.sys == DPM_SYS_DEEP) begin
            state_next.sram = dpm_thermo(state_reg.sram_blocks_reg);
        end else begin
            state_next.sram = '1;
        end
        state_next.freeze = (state_next.sys == DPM_SYS_HIB);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    // reset values are the full-performance run state
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= '0;
            state_reg.sys <= DPM_SYS_FULL;
            for (int c = 0; c < NUM_CORES; c++) begin
                state_reg.core[c] <= DPM_CORE_ACTIVE;
            end
            state_reg.clk_en <= '1;
            state_reg.vtarget <= VTARGET_FULL;
            state_reg.flash_ok <= 1'b1;
            state_reg.hs_clk <= 1'b1;
            state_reg.ls_clk <= 1'b1;
            state_reg.ls_periph <= 1'b1;
            state_reg.ext_periph <= 1'b1;
            state_reg.sram <= '1;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs, straight from the state flops
    // ----------------------------------------------------------------

    assign reg_rdata_out = state_reg.rdata;
    assign core_clk_en_out = state_reg.clk_en;
    assign core_wake_out = state_reg.wake;
    assign regulator_target_out = state_reg.vtarget;
    assign flash_write_allow_out = state_reg.flash_ok;
    assign high_speed_clk_en_out = state_reg.hs_clk;
    assign low_speed_clk_en_out = state_reg.ls_clk;
    assign low_speed_periph_en_out = state_reg.ls_periph;
    assign ext_clock_periph_en_out = state_reg.ext_periph;
    assign sram_retain_out = state_reg.sram;
    assign pin_freeze_out = state_reg.freeze;
    assign device_reset_req_out = state_reg.dev_reset;
    assign sys_mode_out = state_reg.sys;
endmodule

// >>> tb/dpm_checker.sv
// checker: port-level assertions for the power mode controller
`timescale 1ns/100ps
module dpm_checker #(
    parameter int NUM_IRQ = 8,
    parameter int SRAM_BLOCKS = 8
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // watched inputs
    input wire logic [dpm_pkg::NUM_CORES-1:0] debug_attached_in,
    input wire logic hib_wake_in,
    // watched outputs
    input wire logic [dpm_pkg::NUM_CORES-1:0] core_clk_en_out,
    input wire logic [dpm_pkg::NUM_CORES-1:0] core_wake_out,
    input wire logic [1:0] regulator_target_out,
    input wire logic flash_write_allow_out,
    input wire logic high_speed_clk_en_out,
    input wire logic [SRAM_BLOCKS-1:0] sram_retain_out,
    input wire logic pin_freeze_out,
    input wire logic device_reset_req_out,
    input wire logic [1:0] sys_mode_out
);
    import dpm_pkg::*;
    logic [1:0] run_mode_reg;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // ----------------------------------------
    // last run mode, needed to judge the return from deep sleep
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            run_mode_reg <= 2'h0;
        end else if (sys_mode_out < 2'h2) begin
            run_mode_reg <= sys_mode_out;
        end
    end
    AST_REG_TARGET: assert property (sys_mode_out < 2'h2 |-> regulator_target_out ==
        (sys_mode_out == 2'h0 ? VTARGET_FULL : VTARGET_REDUCED)) else $error("bad target");
    AST_NO_FLASH: assert property (sys_mode_out == 2'h1 |-> !flash_write_allow_out)
        else $error("flash write allowed in reduced mode");
    AST_ACTIVE_BLOCKS_DEEP: assert property ((sys_mode_out < 2'h2 && core_clk_en_out != 2'h0)
        |=> sys_mode_out != 2'h2) else $error("deep entry with an active core");
    AST_DEEP_CORES_OFF: assert property (sys_mode_out == 2'h2 |-> core_clk_en_out == 2'h0)
        else $error("core clock running in deep sleep");
    AST_DEEP_HS_OFF: assert property (sys_mode_out == 2'h2 |-> !high_speed_clk_en_out)
        else $error("high speed clock on in deep sleep");
    AST_DEBUG_HOLDS_RUN: assert property ((debug_attached_in != 2'h0 && sys_mode_out < 2'h2)
        |=> sys_mode_out < 2'h2) else $error("left run mode with debugger attached");
    AST_DEEP_RETURN: assert property (sys_mode_out == 2'h2 ##1 sys_mode_out != 2'h2
        |-> sys_mode_out == run_mode_reg) else $error("wrong mode after deep sleep");
    AST_HIB_FROZEN: assert property (sys_mode_out == 2'h3 |-> pin_freeze_out &&
        sram_retain_out == '0) else $error("hibernate not frozen");
    AST_HIB_WAKE_RESET: assert property ((sys_mode_out == 2'h3 && hib_wake_in)
        |=> device_reset_req_out) else $error("no reset on hibernate wake");
    AST_WAKE_PULSE: assert property (core_wake_out != 2'h0 |->
        ((core_wake_out & ~core_clk_en_out) | (core_wake_out & $past(core_clk_en_out))) == 2'h0)
        else $error("wake pulse without core turning active");
endmodule

bind dpm_power_mode_ctrl dpm_checker #(.NUM_IRQ(NUM_IRQ), .SRAM_BLOCKS(SRAM_BLOCKS)) dpm_checker_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .debug_attached_in(debug_attached_in),
    .hib_wake_in(hib_wake_in), .core_clk_en_out(core_clk_en_out), .core_wake_out(core_wake_out),
    .regulator_target_out(regulator_target_out), .flash_write_allow_out(flash_write_allow_out),
    .high_speed_clk_en_out(high_speed_clk_en_out), .sram_retain_out(sram_retain_out),
    .pin_freeze_out(pin_freeze_out), .device_reset_req_out(device_reset_req_out),
    .sys_mode_out(sys_mode_out));

// >>> tb/dpm_core_model.sv
// partner model: two cores whose firmware enters wait with a chosen sleep depth
`timescale 1ns/100ps
module dpm_core_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // firmware commands from the bench
    input wire logic [dpm_pkg::NUM_CORES-1:0] fw_wait_in,
    input wire logic [dpm_pkg::NUM_CORES-1:0] fw_deep_in,
    // controller side
    input wire logic [dpm_pkg::NUM_CORES-1:0] core_clk_en_in,
    input wire logic [dpm_pkg::NUM_CORES-1:0] core_wake_in,
    output logic [dpm_pkg::NUM_CORES-1:0] core_wait_out,
    output logic [dpm_pkg::NUM_CORES-1:0] deep_sleep_select_bit_out
);
    import dpm_pkg::*;
    logic [NUM_CORES-1:0] wait_reg;
    // a woken core leaves wait at once, else it would be seen sleeping again
    assign core_wait_out = wait_reg & ~core_wake_in;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wait_reg <= '0;
            deep_sleep_select_bit_out <= '0;
        end else begin
            for (int i = 0; i < NUM_CORES; i++) begin
                if (core_wake_in[i]) begin
                    wait_reg[i] <= 1'b0;
                end else if (fw_wait_in[i] && core_clk_en_in[i]) begin
                    deep_sleep_select_bit_out[i] <= fw_deep_in[i];
                    wait_reg[i] <= 1'b1;
                end
            end
        end
    end
endmodule

// >>> tb/tb_dpm_power_mode_ctrl.sv
// testbench: power mode scenarios against the dual-core controller
`timescale 1ns/100ps
module tb_dpm_power_mode_ctrl;
    import dpm_pkg::*;
`define CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin \
    $display("ERROR %0t mismatch got %h want %h", $time, act, exp); error_cnt++; end end
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [NUM_CORES-1:0] core_wait, sel_bit, clk_en, wake;
    logic [NUM_CORES-1:0] debug = '0, fw_wait = '0, fw_deep = '0;
    logic [7:0] irq = '0, capable = 8'h01, sram;
    logic hib_wake = 1'b0;
    logic [1:0] target, sys;
    logic flash_ok, hs_clk, ls_clk, ls_periph, ext_periph, freeze, rst_req;
    int error_cnt = 0;
    int total_checks = 0;
    dpm_power_mode_ctrl #(.NUM_IRQ(8), .SRAM_BLOCKS(8)) dpm_power_mode_ctrl_inst (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_write_in(reg_write), .reg_read_in(reg_read),
        .reg_rdata_out(rdata), .core_wait_in(core_wait), .deep_sleep_select_bit_in(sel_bit),
        .debug_attached_in(debug), .periph_irq_in(irq), .deep_wake_capable_in(capable),
        .hib_wake_in(hib_wake), .core_clk_en_out(clk_en), .core_wake_out(wake),
        .regulator_target_out(target), .flash_write_allow_out(flash_ok),
        .high_speed_clk_en_out(hs_clk), .low_speed_clk_en_out(ls_clk),
        .low_speed_periph_en_out(ls_periph), .ext_clock_periph_en_out(ext_periph),
        .sram_retain_out(sram), .pin_freeze_out(freeze), .device_reset_req_out(rst_req),
        .sys_mode_out(sys));
    dpm_core_model dpm_core_model_inst (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .fw_wait_in(fw_wait), .fw_deep_in(fw_deep),
        .core_clk_en_in(clk_en), .core_wake_in(wake), .core_wait_out(core_wait),
        .deep_sleep_select_bit_out(sel_bit));
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    // ----------------------------------------
    // shared drivers
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic rst(input int n);
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        repeat (n) @(posedge clk_in);
        reset_n_in <= 1'b1;
        step(1);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_in);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_in);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk_in);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_in);
        reg_read <= 1'b0;
        #1;
        `CHK(rdata, exp)
    endtask
    // firmware on the chosen cores enters wait; deep selects deep sleep
    task automatic fw(input logic [1:0] w, input logic [1:0] d);
        @(posedge clk_in);
        fw_wait <= w;
        fw_deep <= d;
        @(posedge clk_in);
        fw_wait <= 2'h0;
        step(4);
    endtask
    task automatic pulse(input logic [7:0] v);
        @(posedge clk_in);
        irq <= v;
        step(3);
        irq <= 8'h00;
        step(2);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        `CHK(sys, 2'h0)
        `CHK(clk_en, 2'b11)
        `CHK(hs_clk, 1'b1)
        rd(STATUS_ADDR, 32'h0);
    endtask
    task automatic t_sleep();
        wr(WAKE_MASK_ADDR, 32'h0002_0001);
        rd(WAKE_MASK_ADDR, 32'h0002_0001);
        fw(2'b11, 2'b00);
        `CHK(clk_en, 2'b00)
        rd(STATUS_ADDR, 32'h14);
        pulse(8'h02);
        `CHK(clk_en, 2'b10)
        pulse(8'h01);
        `CHK(clk_en, 2'b11)
    endtask
    task automatic t_deep();
        wr(POWER_CONTROL_ADDR, 32'h1);
        step(2);
        `CHK(target, VTARGET_REDUCED)
        `CHK(flash_ok, 1'b0)
        wr(DEEP_CONFIG_ADDR, 32'h36);
        wr(POWER_CONTROL_ADDR, 32'h3);
        fw(2'b01, 2'b01);
        `CHK(sys, 2'h1)
        wr(POWER_CONTROL_ADDR, 32'h1);
        fw(2'b10, 2'b10);
        `CHK(sys, 2'h1)
        wr(POWER_CONTROL_ADDR, 32'h3);
        step(2);
        `CHK(sys, 2'h2)
        `CHK({hs_clk, ls_clk, ls_periph, ext_periph}, 4'b0110)
        `CHK(sram, 8'h07)
        rd(STATUS_ADDR, 32'h2A);
        pulse(8'h02);
        `CHK(sys, 2'h2)
        pulse(8'h01);
        `CHK(sys, 2'h1)
        rd(STATUS_ADDR, 32'h21);
        pulse(8'h02);
    endtask
    task automatic t_both();
        wr(DEEP_CONFIG_ADDR, 32'h31);
        fw(2'b11, 2'b11);
        `CHK(sys, 2'h2)
        pulse(8'h01);
        `CHK({sys, clk_en}, 4'b0111)
    endtask
    task automatic t_debug();
        wr(POWER_CONTROL_ADDR, 32'h2);
        debug <= 2'b01;
        fw(2'b11, 2'b11);
        `CHK({sys, clk_en}, 4'b0000)
        pulse(8'h03);
        debug <= 2'b00;
        `CHK(clk_en, 2'b11)
    endtask
    task automatic t_hib();
        wr(HIBERNATE_CONTROL_ADDR, 32'h8000_0000);
        fw(2'b11, 2'b11);
        `CHK({sys, freeze}, 3'b111)
        hib_wake <= 1'b1;
        step(2);
        `CHK(rst_req, 1'b1)
        hib_wake <= 1'b0;
        rst(2);
        wr(4'hF, 32'hFFFF_FFFF);
        rd(4'hF, UNMAPPED_READ);
        `CHK({sys, clk_en, target}, 6'b001101)
    endtask
    task automatic wrap_up();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge clk_in);
        error_cnt++;
        wrap_up();
    end
    initial begin
        rst(16);
        t_reset();
        t_sleep();
        t_deep();
        t_both();
        t_debug();
        t_hib();
        wrap_up();
    end
endmodule
